// [logic/dcfsf_fifo.sv]
`timescale 1ns/100ps
module dcfsf_fifo #(
  parameter int DATA_WIDTH = dcfsf_pkg::WIDTH_DEFAULT,
  parameter int ADDR_W = dcfsf_pkg::ADDR_W_DEFAULT
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic push_enable,
  input wire logic [DATA_WIDTH-1:0] push_data,
  input wire logic pop_enable,
  output logic [DATA_WIDTH-1:0] pop_data,
  output logic empty,
  output logic full,
  output logic low_water_flag,
  output logic high_water_flag,
  output logic underflow_error,
  output logic overflow_error
);
  localparam int PW = ADDR_W + 1;
  localparam logic [PW-1:0] DEPTH = PW'(1 << ADDR_W);

  typedef struct packed {
    logic [PW-1:0] wptr;
    logic [PW-1:0] rptr;
    logic [PW-1:0] wgray;
    logic [PW-1:0] rgray;
    logic [PW-1:0] wg_s1;
    logic [PW-1:0] wg_s2;
    logic [PW-1:0] rg_s1;
    logic [PW-1:0] rg_s2;
    logic int_empty;
    logic ahead_valid;
    logic empty;
    logic full;
    logic low_pre;
    logic low;
    logic high_pre;
    logic high;
    logic underflow;
    logic overflow;
    logic [DATA_WIDTH-1:0] stage;
    logic [DATA_WIDTH-1:0] data_out;
    dcfsf_pkg::dcfsf_cfg_t cfg;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } dcfsf_state_t;

  dcfsf_state_t q;
  dcfsf_state_t next_q;
  logic [DATA_WIDTH-1:0] mem [0:(1<<ADDR_W)-1];
  logic [DATA_WIDTH-1:0] rdword;
  logic wr_ok;
  logic take;
  logic sa;
  logic single;
  logic pipe;
  logic [PW-1:0] wp_n;
  logic [PW-1:0] rp_n;
  logic [PW-1:0] wseen;
  logic [PW-1:0] rseen;
  logic [PW-1:0] fill_r;
  logic [PW-1:0] fill_w;
  logic [PW-1:0] free_w;
  logic cond_low;
  logic cond_high;

  function automatic logic [PW-1:0] bin2gray(input logic [PW-1:0] b);
    return b ^ (b >> 1);
  endfunction : bin2gray

  function automatic logic [PW-1:0] gray2bin(input logic [PW-1:0] g);
    logic [PW-1:0] b;
    b[PW-1] = g[PW-1];
    for (int i = PW - 2; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction : gray2bin

  assign rdword = mem[q.rptr[ADDR_W-1:0]];

  always_comb begin
    next_q = q;
    single = q.cfg.single_clock;
    // Show-ahead is ignored in single-clock mode rather than misbehaving
    sa = q.cfg.show_ahead && !single;
    pipe = single && q.cfg.out_pipe;
    wr_ok = push_enable && !q.full;
    wp_n = q.wptr + PW'(wr_ok);
    if (sa) begin
      take = !q.int_empty && (!q.ahead_valid || pop_enable);
    end else begin
      take = pop_enable && !q.int_empty;
    end
    rp_n = q.rptr + PW'(take);
    wseen = single ? wp_n : gray2bin(q.wg_s2);
    rseen = single ? rp_n : gray2bin(q.rg_s2);
    next_q.wptr = wp_n;
    next_q.rptr = rp_n;
    next_q.wgray = bin2gray(wp_n);
    next_q.rgray = bin2gray(rp_n);
    // one clock, so no phase slip
    next_q.wg_s1 = q.wgray;
    next_q.wg_s2 = q.wg_s1;
    next_q.rg_s1 = q.rgray;
    next_q.rg_s2 = q.rg_s1;
    next_q.int_empty = (rp_n == wseen);
    next_q.ahead_valid = sa && (take || (q.ahead_valid && !pop_enable));
    next_q.empty = sa ? !next_q.ahead_valid : next_q.int_empty;
    // full at once, falls via sync chain in dual-clock mode
    fill_w = wp_n - rseen;
    next_q.full = (fill_w == DEPTH);
    fill_r = wseen - rp_n;
    free_w = DEPTH - fill_w;
    cond_low = fill_r <= PW'(q.cfg.low_thr);
    cond_high = free_w <= PW'(q.cfg.high_thr);
    next_q.low_pre = cond_low;
    next_q.low = single ? cond_low : q.low_pre;
    next_q.high_pre = cond_high;
    next_q.high = single ? cond_high : q.high_pre;
    // clears with pop or empty low
    next_q.underflow = pop_enable && q.empty;
    // clears with push or full low
    next_q.overflow = push_enable && q.full;
    if (take) begin
      if (pipe) begin
        next_q.stage = rdword;
      end else begin
        next_q.data_out = rdword;
      end
    end
    if (pipe) begin
      next_q.data_out = q.cfg.out_rst ? DATA_WIDTH'(q.cfg.reset_value) : q.stage;
    end
    // Bus: read data and error prepared in setup, pready high except while reset loads it low
    next_q.pready = 1'b1;
    if (psel && !penable) begin
      next_q.pslverr = 1'b0;
      next_q.prdata = 32'h00000000;
      unique case (paddr)
        dcfsf_pkg::OFF_CTRL: begin
          next_q.prdata[dcfsf_pkg::CTRL_SHOW_AHEAD] = q.cfg.show_ahead;
          next_q.prdata[dcfsf_pkg::CTRL_SINGLE_CLOCK] = q.cfg.single_clock;
          next_q.prdata[dcfsf_pkg::CTRL_OUT_PIPE] = q.cfg.out_pipe;
          next_q.prdata[dcfsf_pkg::CTRL_OUT_RST] = q.cfg.out_rst;
        end
        dcfsf_pkg::OFF_THRESH: begin
          next_q.prdata[dcfsf_pkg::THR_LOW_LSB +: dcfsf_pkg::THR_W] = q.cfg.low_thr;
          next_q.prdata[dcfsf_pkg::THR_HIGH_LSB +: dcfsf_pkg::THR_W] = q.cfg.high_thr;
        end
        dcfsf_pkg::OFF_RESET_VALUE: next_q.prdata = q.cfg.reset_value;
        dcfsf_pkg::OFF_INIT_VALUE: next_q.prdata = q.cfg.init_value;
        dcfsf_pkg::OFF_STATUS: begin
          next_q.prdata[dcfsf_pkg::ST_EMPTY] = q.empty;
          next_q.prdata[dcfsf_pkg::ST_FULL] = q.full;
          next_q.prdata[dcfsf_pkg::ST_LOW] = q.low;
          next_q.prdata[dcfsf_pkg::ST_HIGH] = q.high;
          next_q.prdata[dcfsf_pkg::ST_UNDERFLOW] = q.underflow;
          next_q.prdata[dcfsf_pkg::ST_OVERFLOW] = q.overflow;
        end
        dcfsf_pkg::OFF_COUNT: next_q.prdata = 32'(q.wptr - q.rptr);
        default: next_q.pslverr = 1'b1;
      endcase
    end
    if (psel && penable && pwrite) begin
      unique case (paddr)
        dcfsf_pkg::OFF_CTRL: begin
          next_q.cfg.show_ahead = pwdata[dcfsf_pkg::CTRL_SHOW_AHEAD];
          next_q.cfg.single_clock = pwdata[dcfsf_pkg::CTRL_SINGLE_CLOCK];
          next_q.cfg.out_pipe = pwdata[dcfsf_pkg::CTRL_OUT_PIPE];
          next_q.cfg.out_rst = pwdata[dcfsf_pkg::CTRL_OUT_RST];
        end
        dcfsf_pkg::OFF_THRESH: begin
          next_q.cfg.low_thr = pwdata[dcfsf_pkg::THR_LOW_LSB +: dcfsf_pkg::THR_W];
          next_q.cfg.high_thr = pwdata[dcfsf_pkg::THR_HIGH_LSB +: dcfsf_pkg::THR_W];
        end
        dcfsf_pkg::OFF_RESET_VALUE: next_q.cfg.reset_value = pwdata;
        dcfsf_pkg::OFF_INIT_VALUE: begin
          next_q.cfg.init_value = pwdata;
          if (pipe) begin
            next_q.data_out = DATA_WIDTH'(pwdata);
            // Stage too, else the next edge overwrites the value
            next_q.stage = DATA_WIDTH'(pwdata);
          end
        end
        default: next_q.cfg = q.cfg;
      endcase
    end
    if (reset) begin
      next_q = '0;
      next_q.empty = 1'b1;
      next_q.int_empty = 1'b1;
      next_q.low = 1'b1;
      next_q.low_pre = 1'b1;
      next_q.stage = DATA_WIDTH'(dcfsf_pkg::RST_INIT_VALUE);
      next_q.data_out = DATA_WIDTH'(dcfsf_pkg::RST_INIT_VALUE);
      next_q.cfg.show_ahead = dcfsf_pkg::RST_SHOW_AHEAD;
      next_q.cfg.single_clock = dcfsf_pkg::RST_SINGLE_CLOCK;
      next_q.cfg.out_pipe = dcfsf_pkg::RST_OUT_PIPE;
      next_q.cfg.low_thr = dcfsf_pkg::RST_LOW_THR;
      next_q.cfg.high_thr = dcfsf_pkg::RST_HIGH_THR;
      next_q.cfg.reset_value = dcfsf_pkg::RST_RESET_VALUE;
      next_q.cfg.init_value = dcfsf_pkg::RST_INIT_VALUE;
    end
  end

  always_ff @(posedge clk) begin
    q <= next_q;
  end

  // Memory is never cleared; reset rewinds pointers and blocks writes
  always_ff @(posedge clk) begin
    if (wr_ok && !reset) begin
      mem[q.wptr[ADDR_W-1:0]] <= push_data;
    end
  end

  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign pop_data = q.data_out;
  assign empty = q.empty;
  assign full = q.full;
  assign low_water_flag = q.low;
  assign high_water_flag = q.high;
  assign underflow_error = q.underflow;
  assign overflow_error = q.overflow;

  sequence s_idle_write;
    !single && !sa && q.empty && wr_ok && q.wptr == q.rptr
      && q.wg_s1 == q.wgray && q.wg_s2 == q.wgray;
  endsequence
  property p_empty_fall;
    @(posedge clk) disable iff (reset)
      s_idle_write ##1 (!pop_enable && !reset)[*3] |=> !q.empty;
  endproperty
  a_empty_fall: assert property (p_empty_fall) else $error("empty fall latency wrong");

  property p_empty_hold;
    @(posedge clk) disable iff (reset) s_idle_write |=> q.empty[*3];
  endproperty
  a_empty_hold: assert property (p_empty_hold) else $error("empty fell too early");

  property p_empty_rise;
    @(posedge clk) disable iff (reset)
      (!sa && take && (q.rptr + PW'(1)) == wseen) |=> q.empty;
  endproperty
  a_empty_rise: assert property (p_empty_rise) else $error("empty missed last read");

  property p_rptr_frozen;
    @(posedge clk) disable iff (reset) (!sa && q.empty) |=> $stable(q.rptr);
  endproperty
  a_rptr_frozen: assert property (p_rptr_frozen) else $error("read pointer moved");

  property p_wptr_frozen;
    @(posedge clk) disable iff (reset) q.full |=> $stable(q.wptr);
  endproperty
  a_wptr_frozen: assert property (p_wptr_frozen) else $error("write pointer moved");

  sequence s_read_full;
    !single && q.full && take && !push_enable && q.rg_s2 == q.rgray
      && q.rg_s1 == q.rgray;
  endsequence
  property p_full_fall;
    @(posedge clk) disable iff (reset)
      s_read_full ##1 (!push_enable && !reset)[*3] |=> !q.full;
  endproperty
  a_full_fall: assert property (p_full_fall) else $error("full fall latency wrong");

  property p_single_empty;
    @(posedge clk) disable iff (reset)
      (single && $stable(single)) |-> q.empty == (q.wptr == q.rptr);
  endproperty
  a_single_empty: assert property (p_single_empty) else $error("single empty lags");

  property p_underflow;
    @(posedge clk) disable iff (reset)
      (pop_enable && q.empty) |=> (q.underflow && $stable(q.rptr));
  endproperty
  a_underflow: assert property (p_underflow) else $error("underflow not raised");

  property p_underflow_clr;
    @(posedge clk) disable iff (reset) (!pop_enable || !q.empty) |=> !q.underflow;
  endproperty
  a_underflow_clr: assert property (p_underflow_clr) else $error("underflow stuck");

  property p_overflow;
    @(posedge clk) disable iff (reset)
      (push_enable && q.full) |=> (q.overflow && $stable(q.wptr));
  endproperty
  a_overflow: assert property (p_overflow) else $error("overflow not raised");

  property p_overflow_clr;
    @(posedge clk) disable iff (reset) (!push_enable || !q.full) |=> !q.overflow;
  endproperty
  a_overflow_clr: assert property (p_overflow_clr) else $error("overflow stuck");

  property p_low_up;
    @(posedge clk) disable iff (reset)
      (!single && $stable(single) && cond_low) |=> ##1 q.low;
  endproperty
  a_low_up: assert property (p_low_up) else $error("low-water late");

  property p_low_fall;
    @(posedge clk) disable iff (reset)
      (!single && $stable(single) && !cond_low) |=> ##1 !q.low;
  endproperty
  a_low_fall: assert property (p_low_fall) else $error("low-water stuck");

  property p_high_up;
    @(posedge clk) disable iff (reset)
      (!single && $stable(single) && cond_high) |=> ##1 q.high;
  endproperty
  a_high_up: assert property (p_high_up) else $error("high-water late");

  property p_pipe_data;
    @(posedge clk) disable iff (reset)
      (pipe && take && !q.cfg.out_rst) ##1 (pipe && !q.cfg.out_rst && !psel)
        |=> q.data_out == $past(rdword, 2);
  endproperty
  a_pipe_data: assert property (p_pipe_data) else $error("pipeline data wrong");

  property p_reset_flags;
    @(posedge clk) reset |=> (q.empty && q.low && !q.full && !q.high);
  endproperty
  a_reset_flags: assert property (p_reset_flags) else $error("reset flags wrong");
endmodule : dcfsf_fifo

// [common/dcfsf_pkg.sv]
package dcfsf_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_THRESH = 8'h04;
  localparam logic [7:0] OFF_RESET_VALUE = 8'h08;
  localparam logic [7:0] OFF_INIT_VALUE = 8'h0C;
  localparam logic [7:0] OFF_STATUS = 8'h10;
  localparam logic [7:0] OFF_COUNT = 8'h14;
  // Control field positions
  localparam int CTRL_SHOW_AHEAD = 0;
  localparam int CTRL_SINGLE_CLOCK = 1;
  localparam int CTRL_OUT_PIPE = 2;
  localparam int CTRL_OUT_RST = 3;
  // Threshold field positions, 13 bits each
  localparam int THR_W = 13;
  localparam int THR_LOW_LSB = 0;
  localparam int THR_HIGH_LSB = 16;
  // Status field positions
  localparam int ST_EMPTY = 0;
  localparam int ST_FULL = 1;
  localparam int ST_LOW = 2;
  localparam int ST_HIGH = 3;
  localparam int ST_UNDERFLOW = 4;
  localparam int ST_OVERFLOW = 5;
  // Values after reset
  localparam logic RST_SHOW_AHEAD = 1'b0;
  localparam logic RST_SINGLE_CLOCK = 1'b0;
  localparam logic RST_OUT_PIPE = 1'b1;
  localparam logic [THR_W-1:0] RST_LOW_THR = 13'h0005;
  localparam logic [THR_W-1:0] RST_HIGH_THR = 13'h0004;
  localparam logic [31:0] RST_RESET_VALUE = 32'h00000000;
  localparam logic [31:0] RST_INIT_VALUE = 32'h00000000;
  // Default word width and address width of the memory
  localparam int WIDTH_DEFAULT = 4;
  localparam int ADDR_W_DEFAULT = 13;
  // Cycle counts of the dual-clock flag paths
  localparam int EMPTY_FALL_STD = 3;
  localparam int EMPTY_FALL_AHEAD = 4;
  localparam int FULL_FALL = 3;

  typedef struct packed {
    logic show_ahead;
    logic single_clock;
    logic out_pipe;
    logic out_rst;
    logic [THR_W-1:0] low_thr;
    logic [THR_W-1:0] high_thr;
    logic [31:0] reset_value;
    logic [31:0] init_value;
  } dcfsf_cfg_t;
endpackage : dcfsf_pkg

// [tb/dcfsf_user_model.sv]
`timescale 1ns/100ps
module dcfsf_user_model #(
  parameter int DW = 4
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic do_push,
  input wire logic do_pop,
  input wire logic [DW-1:0] wdata,
  output logic push_enable,
  output logic [DW-1:0] push_data,
  output logic pop_enable
);
  logic pe = 1'b0;
  logic qe = 1'b0;
  logic [DW-1:0] pd = '0;
  assign push_enable = pe;
  assign pop_enable = qe;
  assign push_data = pd;
  always_ff @(posedge clk) begin
    pe <= do_push && !reset;
    qe <= do_pop && !reset;
    // Idle bus toggles so a stale word cannot pass
    pd <= (do_push && !reset) ? wdata : ~pd;
  end
endmodule : dcfsf_user_model

// [tb/dcfsf_fifo_tb.sv]
`timescale 1ns/100ps
module dcfsf_fifo_tb;
  localparam int DW = 9;
  localparam int DEPTH = 16;
  logic clk, reset, psel, penable, pwrite, pready, pslverr, er, do_push, do_pop;
  logic watch_on, pend, push_enable, pop_enable, empty, full, low_water_flag;
  logic high_water_flag, underflow_error, overflow_error;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [DW-1:0] wdata, push_data, pop_data, word;
  logic [31:0] exp_q[$];
  int err_count, compares, n;

  dcfsf_fifo #(.DATA_WIDTH(DW), .ADDR_W(4)) u_dut (.clk(clk), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .push_enable(push_enable), .push_data(push_data),
    .pop_enable(pop_enable), .pop_data(pop_data), .empty(empty), .full(full),
    .low_water_flag(low_water_flag), .high_water_flag(high_water_flag),
    .underflow_error(underflow_error), .overflow_error(overflow_error));
  dcfsf_user_model #(.DW(DW)) u_user (.clk(clk), .reset(reset), .do_push(do_push),
    .do_pop(do_pop), .wdata(wdata), .push_enable(push_enable), .push_data(push_data),
    .pop_enable(pop_enable));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic report_and_stop;
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : report_and_stop

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Requests for a run of cycles; the last one lands one edge after return
  task automatic pulse(input logic psh, input int cycles, input logic note);
    for (int i = 0; i < cycles; i++) begin
      if (psh) word = DW'($urandom);
      @(posedge clk);
      if (psh) begin
        do_push <= 1'b1;
        wdata <= word;
        if (note) exp_q.push_back(32'(word));
      end else do_pop <= 1'b1;
    end
    @(posedge clk);
    do_push <= 1'b0;
    do_pop <= 1'b0;
  endtask : pulse

  task automatic wait_flag(input logic on_full, input logic lvl);
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while ((on_full ? full : empty) !== lvl && n < 40);
  endtask : wait_flag

  always @(negedge clk) begin
    if (pend) check(32'(pop_data), exp_q.size() > 0 ? exp_q.pop_front() : 32'hFFFFFFFF);
    pend = watch_on && pop_enable === 1'b1 && empty === 1'b0;
  end

  initial begin
    #200000;
    err_count++;
    report_and_stop();
  end

  initial begin
    {reset, psel, penable, pwrite, do_push, do_pop, watch_on, pend} = 8'h80;
    {paddr, pwdata, wdata, word} = '0;
    err_count = 0;
    compares = 0;
    void'($urandom(67));
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    #1 check(32'({empty, low_water_flag, full, high_water_flag, underflow_error,
      overflow_error}), 32'h30);
    apb(1'b0, dcfsf_pkg::OFF_CTRL, 32'h0);
    check(rd, 32'h4);
    apb(1'b0, dcfsf_pkg::OFF_THRESH, 32'h0);
    check(rd, {3'h0, dcfsf_pkg::RST_HIGH_THR, 3'h0, dcfsf_pkg::RST_LOW_THR});
    apb(1'b0, 8'h20, 32'h0);
    check(32'(er), 32'h1);
    apb(1'b1, dcfsf_pkg::OFF_STATUS, 32'h3F);
    apb(1'b0, dcfsf_pkg::OFF_STATUS, 32'h0);
    check(rd, 32'h5);
    $display("test reset done");
    watch_on = 1'b1;
    pulse(1'b1, 1, 1'b1);
    wait_flag(1'b0, 1'b0);
    check(32'(n - 1), 32'(dcfsf_pkg::EMPTY_FALL_STD));
    pulse(1'b0, 1, 1'b0);
    wait_flag(1'b0, 1'b1);
    check(32'(n - 1), 32'h0);
    pulse(1'b1, DEPTH, 1'b1);
    wait_flag(1'b1, 1'b1);
    check(32'(n - 1), 32'h0);
    repeat (5) @(posedge clk);
    #1 check(32'({high_water_flag, low_water_flag}), 32'h2);
    pulse(1'b1, 1, 1'b0);
    @(posedge clk);
    #1 check(32'(overflow_error), 32'h1);
    @(posedge clk);
    #1 check(32'(overflow_error), 32'h0);
    apb(1'b0, dcfsf_pkg::OFF_COUNT, 32'h0);
    check(rd, 32'(DEPTH));
    pulse(1'b0, 1, 1'b0);
    wait_flag(1'b1, 1'b0);
    check(32'(n - 1), 32'(dcfsf_pkg::FULL_FALL));
    pulse(1'b0, DEPTH, 1'b0);
    @(posedge clk);
    #1 check(32'(underflow_error), 32'h1);
    @(posedge clk);
    #1 check(32'({underflow_error, empty, low_water_flag}), 32'h3);
    apb(1'b0, dcfsf_pkg::OFF_COUNT, 32'h0);
    check(rd, 32'h0);
    check(32'(exp_q.size()), 32'h0);
    $display("test dual standard done");
    apb(1'b1, dcfsf_pkg::OFF_CTRL, 32'h2);
    pulse(1'b1, 1, 1'b1);
    wait_flag(1'b0, 1'b0);
    check(32'(n - 1), 32'h0);
    pulse(1'b0, 1, 1'b0);
    wait_flag(1'b0, 1'b1);
    check(32'(n - 1), 32'h0);
    watch_on = 1'b0;
    apb(1'b1, dcfsf_pkg::OFF_CTRL, 32'h6);
    apb(1'b1, dcfsf_pkg::OFF_INIT_VALUE, 32'h1A5);
    repeat (2) @(posedge clk);
    #1 check(32'(pop_data), 32'h1A5);
    pulse(1'b1, 1, 1'b0);
    repeat (2) @(posedge clk);
    pulse(1'b0, 1, 1'b0);
    @(posedge clk);
    #1 check(32'(pop_data), 32'h1A5);
    @(posedge clk);
    #1 check(32'(pop_data), 32'(word));
    apb(1'b1, dcfsf_pkg::OFF_RESET_VALUE, 32'h0C3);
    apb(1'b1, dcfsf_pkg::OFF_CTRL, 32'hE);
    repeat (2) @(posedge clk);
    #1 check(32'(pop_data), 32'h0C3);
    $display("test single clock done");
    // pipeline select kept at 1 in dual mode
    apb(1'b1, dcfsf_pkg::OFF_CTRL, 32'h5);
    pulse(1'b1, 1, 1'b0);
    wait_flag(1'b0, 1'b0);
    check(32'(n - 1), 32'(dcfsf_pkg::EMPTY_FALL_AHEAD));
    check(32'(pop_data), 32'(word));
    pulse(1'b0, 1, 1'b0);
    wait_flag(1'b0, 1'b1);
    check(32'(n - 1), 32'h0);
    $display("test show-ahead done");
    report_and_stop();
  end
endmodule : dcfsf_fifo_tb
